/* clk_pulse_map.svh */
// register offsets, field positions, reset values and timing counts of the clock control block
`ifndef CLK_PULSE_MAP_SVH
`define CLK_PULSE_MAP_SVH

// byte offsets on the register bus
`define OFS_SYSTEM_CLOCK_CONTROL 32'h0000_0000
`define OFS_PLL_MULTIPLIER_CONTROL 32'h0000_0004
`define OFS_STANDBY_CONTROL 32'h0000_0008
`define OFS_CLOCK_STATUS 32'h0000_000c

// system_clock_control fields
`define SCC_CLOCK_OUT_DISABLE 7
`define SCC_SPARE 6
`define SCC_SWITCH_MODE 3
`define SCC_DIVIDER_HI 2
`define SCC_WRITE_MASK 8'hcf

// pll_multiplier_control fields
`define PMC_SPARE 3
`define PMC_MULT_HI 1
`define PMC_WRITE_MASK 8'h0b

// standby_control field
`define STC_SETTLE_HI 3

// reset values
`define SCC_RESET 8'h00
`define PMC_RESET 8'h00
`define STC_RESET 8'h00

// divider and multiplier codes
`define DIV_1_1 3'h0
`define DIV_1_2 3'h1
`define DIV_1_4 3'h2
`define MULT_X1 2'h0

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// settle time: (field + 1) times this many system clock cycles
`define SETTLE_UNIT_CYCLES 11'h040
`define SETTLE_W 11

`endif

/* clk_pulse_pkg.sv */
// types shared by the clock control block
package clk_pulse_pkg;

  // power state of the generator, gray coded along run, standby, settle, hardware standby
  typedef enum logic [1:0] {
    st_run = 2'h0,
    st_standby = 2'h1,
    st_settle = 2'h3,
    st_hw_standby = 2'h2
  } cpg_state_t;

  // which register an address selects
  typedef enum logic [2:0] {
    sel_system_clock,
    sel_pll,
    sel_standby,
    sel_status,
    sel_none
  } reg_sel_t;

  typedef logic [7:0] reg8_t;

endpackage

/* level_sync.sv */
// two flip-flop synchroniser for pin levels
module level_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_stage; // read only by the second stage

  // both stages reset low so nothing wakes during reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      first_stage <= '0;
      sync_out <= '0;
    end else begin
      first_stage <= async_in;
      sync_out <= first_stage;
    end
  end

endmodule

/* rate_divider.sv */
// divides the generator clock into 1/1, 1/2 or 1/4 rate enable ticks
module rate_divider (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic [1:0] ratio_mask,
  // divided rate tick
  output logic tick
);

  logic [1:0] phase; // free count, masked to the selected ratio

  // counter stops with the generator so the first tick after a restart is aligned
  always_ff @(posedge mclk) begin
    if (reset || !run) begin
      phase <= 2'h0;
      tick <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      tick <= ((phase & ratio_mask) == 2'h0); // see (R11)
    end
  end

endmodule

/* clock_pulse_generator_ctrl.sv */
// control logic of the clock pulse generator with its register slave
// What this block does
// (R1) frequency changes only through register writes
// (R2) clock pin follows disable bit and power mode
// (R3) spare bits six and three store writes
// (R4) fixed reserved bits read zero, ignore writes
// (R5) control bit two reads zero, never changes
// (R6) deferred mode: multiplier applies at software standby
// (R7) immediate mode: multiplier applies on write
// (R8) divider codes give 1/1, 1/2, 1/4
// (R9) multiplier codes give x1, x2, x4
// (R10) standby adopts multiplier, settles, then resumes
// (R11) reduced rates derive from generator output clock
// (R12) both control registers reset to zero
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`include "clk_pulse_map.svh"

module clock_pulse_generator_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // axi4-lite write address
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // power mode requests
  input wire logic standby_request,
  input wire logic standby_wake,
  input wire logic hw_standby_n,
  // system clock output pin
  output logic clock_out,
  output logic clock_out_oe,
  // generator state towards the chip
  output logic clock_tick,
  output logic generator_running,
  output logic [1:0] active_multiplier,
  output clk_pulse_pkg::cpg_state_t power_state
);

  import clk_pulse_pkg::*;

  // maps a bus address onto a register select, shared by both channels
  function automatic reg_sel_t decode(input logic [31:0] addr);
    reg_sel_t sel;
    sel = sel_none;
    if (addr == `OFS_SYSTEM_CLOCK_CONTROL) begin
      sel = sel_system_clock;
    end else if (addr == `OFS_PLL_MULTIPLIER_CONTROL) begin
      sel = sel_pll;
    end else if (addr == `OFS_STANDBY_CONTROL) begin
      sel = sel_standby;
    end else if (addr == `OFS_CLOCK_STATUS) begin
      sel = sel_status;
    end
    return sel;
  endfunction

  // divider code to phase mask; prohibited codes fall back to full rate
  function automatic logic [1:0] divider_mask(input logic [2:0] code);
    logic [1:0] mask;
    mask = 2'h0;
    if (code == `DIV_1_2) begin
      mask = 2'h1;
    end else if (code == `DIV_1_4) begin
      mask = 2'h3;
    end
    return mask;
  endfunction

  // software registers
  reg8_t system_clock_control; // pin disable, spare, switch mode, divider
  reg8_t pll_multiplier_control; // spare and requested multiplier
  reg8_t standby_control; // settle time field

  // write channel holding state
  logic aw_held; // an address is parked waiting for its data
  logic w_held; // data is parked waiting for its address
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // generator state
  cpg_state_t state;
  cpg_state_t next_state;
  logic [`SETTLE_W-1:0] settle_count; // cycles left before the clock resumes
  logic [1:0] pin_sync; // synchronised wake and hardware standby levels
  logic tick; // divided rate enable from the divider

  // write channel handshakes and the moment a write lands
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire b_done = bvalid & bready;
  wire have_aw = aw_held | aw_take;
  wire have_w = w_held | w_take;
  wire write_fire = have_aw & have_w & ~bvalid;
  wire next_aw_held = have_aw & ~write_fire;
  wire next_w_held = have_w & ~write_fire;
  wire next_bvalid = write_fire | (bvalid & ~bready);

  // address and data of the landing write, parked or straight from the bus
  wire [31:0] wr_addr = aw_held ? awaddr_q : awaddr;
  wire [31:0] wr_data = w_held ? wdata_q : wdata;
  wire [3:0] wr_strb = w_held ? wstrb_q : wstrb;
  wire reg_sel_t wr_sel = decode(wr_addr);
  wire lane0 = wr_strb[0]; // registers are eight bits wide, in byte lane 0

  // per register write strobes
  wire wr_sys = write_fire & lane0 & (wr_sel == sel_system_clock);
  wire wr_pll = write_fire & lane0 & (wr_sel == sel_pll);
  wire wr_stby = write_fire & lane0 & (wr_sel == sel_standby);

  // read channel
  wire ar_take = arvalid & arready;
  wire next_rvalid = ar_take | (rvalid & ~rready);
  wire reg_sel_t rd_sel = decode(araddr);

  // synchronised pins
  wire wake_level = pin_sync[0];
  wire hw_standby = pin_sync[1]; // already inverted to active high at the synchroniser input

  // register fields in use
  wire clock_out_disable = system_clock_control[`SCC_CLOCK_OUT_DISABLE];
  wire multiplier_switch_mode = system_clock_control[`SCC_SWITCH_MODE];
  wire [2:0] divider_select = system_clock_control[`SCC_DIVIDER_HI:0];
  wire [1:0] multiplier_select = pll_multiplier_control[`PMC_MULT_HI:0];
  wire [3:0] standby_settle = standby_control[`STC_SETTLE_HI:0];
  wire [`SETTLE_W-1:0] settle_load = `SETTLE_W'(({7'h00, standby_settle} + `SETTLE_W'h1)
    * `SETTLE_UNIT_CYCLES - `SETTLE_W'h1);

  // status word: active multiplier, power state, multiplier change pending
  wire pending_change = (active_multiplier != multiplier_select);
  wire [7:0] clock_status = {3'h0, pending_change, state, active_multiplier};

  // read mux, unmapped addresses read zero
  wire [7:0] rd_byte = (rd_sel == sel_system_clock) ? system_clock_control :
                       (rd_sel == sel_pll) ? pll_multiplier_control :
                       (rd_sel == sel_standby) ? standby_control :
                       (rd_sel == sel_status) ? clock_status : 8'h00;

  // entering software standby from run
  wire enter_standby = (state == st_run) & (next_state == st_standby);

  // wake and hardware standby pins are asynchronous to mclk
  level_sync #(
    .WIDTH(2)
  ) pin_sync_inst (
    .mclk(mclk),
    .reset(reset),
    .async_in({~hw_standby_n, standby_wake}),
    .sync_out(pin_sync)
  );

  // divided rate ticks, stopped whenever the generator is halted
  rate_divider divider_inst (
    .mclk(mclk),
    .reset(reset),
    .run(state == st_run),
    .ratio_mask(divider_mask(divider_select)), // see (R8)
    .tick(tick)
  );

  // write channel bookkeeping; address and data may come in either order
  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awready <= ~next_aw_held & ~next_bvalid;
      wready <= ~next_w_held & ~next_bvalid;
      bvalid <= next_bvalid;
      if (write_fire) begin
        // unmapped or status writes are refused with an error answer
        bresp <= (wr_sel == sel_none || wr_sel == sel_status) ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  // parked write address and data
  always_ff @(posedge mclk) begin
    if (reset) begin
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        awaddr_q <= awaddr;
      end
      if (w_take) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  // read channel: one read in flight, answered the cycle after the address
  always_ff @(posedge mclk) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      arready <= ~next_rvalid;
      rvalid <= next_rvalid;
      if (ar_take) begin
        rdata <= {24'h00_0000, rd_byte};
        rresp <= (rd_sel == sel_none) ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  // software registers; masks keep fixed reserved bits at zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      system_clock_control <= `SCC_RESET; // see (R12)
      pll_multiplier_control <= `PMC_RESET; // see (R12)
      standby_control <= `STC_RESET;
    end else begin
      if (wr_sys) begin
        // bit 6 stores, bits 5 and 4 stay zero
        system_clock_control <= wr_data[7:0] & `SCC_WRITE_MASK; // see (R3) see (R4) see (R8)
      end
      if (wr_pll) begin
        // bit 3 stores, bits 7 to 4 and bit 2 stay zero
        pll_multiplier_control <= wr_data[7:0] & `PMC_WRITE_MASK; // see (R3) see (R4) see (R5)
      end
      if (wr_stby) begin
        standby_control <= {4'h0, wr_data[`STC_SETTLE_HI:0]};
      end
    end
  end

  // power state transitions; hardware standby overrides everything
  always_comb begin
    next_state = state;
    unique case (state)
      st_run: begin
        if (hw_standby) begin
          next_state = st_hw_standby;
        end else if (standby_request) begin
          next_state = st_standby; // see (R10)
        end
      end
      st_standby: begin
        if (hw_standby) begin
          next_state = st_hw_standby;
        end else if (wake_level) begin
          next_state = st_settle; // see (R10)
        end
      end
      st_settle: begin
        if (hw_standby) begin
          next_state = st_hw_standby;
        end else if (settle_count == `SETTLE_W'h0) begin
          next_state = st_run; // see (R10)
        end
      end
      st_hw_standby: begin
        // leaving hardware standby also waits out the settle time
        if (!hw_standby) begin
          next_state = st_settle;
        end
      end
    endcase
  end

  // state register and settle countdown
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= st_run;
      settle_count <= `SETTLE_W'h0;
    end else begin
      state <= next_state;
      if (next_state == st_settle && state != st_settle) begin
        settle_count <= settle_load; // see (R10)
      end else if (state == st_settle && settle_count != `SETTLE_W'h0) begin
        settle_count <= settle_count - `SETTLE_W'h1;
      end
    end
  end

  // multiplier in force: changes only on a write or on standby entry
  always_ff @(posedge mclk) begin
    if (reset) begin
      active_multiplier <= `MULT_X1;
    end else if (wr_pll && multiplier_switch_mode) begin
      active_multiplier <= wr_data[`PMC_MULT_HI:0]; // see (R7) see (R9) see (R1)
    end else if (enter_standby && !multiplier_switch_mode) begin
      active_multiplier <= multiplier_select; // see (R6) see (R10) see (R1)
    end
  end

  // clock pin: toggles per divided tick while running, else high or released
  always_ff @(posedge mclk) begin
    if (reset) begin
      clock_out <= 1'b1;
      clock_out_oe <= 1'b1;
    end else if (next_state == st_hw_standby) begin
      // follows the state being entered so the pin agrees with power_state
      clock_out <= 1'b1; // see (R2)
      clock_out_oe <= 1'b0; // see (R2)
    end else if (next_state != st_run || clock_out_disable) begin
      clock_out <= 1'b1; // see (R2)
      clock_out_oe <= 1'b1;
    end else begin
      clock_out <= tick ? ~clock_out : clock_out; // see (R2)
      clock_out_oe <= 1'b1;
    end
  end

  // registered copies of the generator state for the chip
  always_ff @(posedge mclk) begin
    if (reset) begin
      clock_tick <= 1'b0;
      generator_running <= 1'b1;
      power_state <= st_run;
    end else begin
      // gated by the next state: a tick already in the divider must not leak into a halt
      clock_tick <= tick & (next_state == st_run); // see (R11)
      generator_running <= (next_state == st_run);
      power_state <= next_state;
    end
  end

endmodule

/* clock_ctrl_props.sv */
// concurrent checks on the clock control block ports
module clock_ctrl_props (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // power pins
  input wire logic standby_request,
  input wire logic hw_standby_n,
  // generator outputs
  input wire logic clock_out,
  input wire logic clock_out_oe,
  input wire logic clock_tick,
  input wire logic generator_running,
  input wire logic [1:0] active_multiplier,
  input clk_pulse_pkg::cpg_state_t power_state
);
  import clk_pulse_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // address and data taken together
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // standby asked in run, hardware standby pin quiet long enough to rule it out
  sequence s_enter;
    power_state == st_run && standby_request && hw_standby_n && $past(hw_standby_n)
      && $past(hw_standby_n, 2);
  endsequence
  a_write_answer: assert property (s_wr_taken |=> bvalid)
    else $error("write response missing");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  a_write_gap: assert property (bvalid |-> !awready && !wready)
    else $error("write channels ready during response");
  a_read_gap: assert property (rvalid |-> !arready)
    else $error("read channel ready during data");
  a_standby_pin: assert property (power_state == st_standby |-> clock_out && clock_out_oe)
    else $error("pin not high in standby");
  a_hw_pin_off: assert property (!hw_standby_n [*5] |-> !clock_out_oe)
    else $error("pin driven in hardware standby");
  a_halt_no_tick: assert property (!generator_running |-> !clock_tick)
    else $error("tick while halted");
  a_run_flag: assert property (generator_running |-> power_state == st_run)
    else $error("running outside run");
  a_standby_entry: assert property (s_enter |=> power_state == st_standby)
    else $error("standby not entered");
  a_standby_halt: assert property (s_enter |=> !generator_running)
    else $error("generator runs in standby");
  a_standby_mult: assert property ((power_state == st_standby && $past(power_state) == st_standby)
    |-> $stable(active_multiplier))
    else $error("multiplier moved in standby");
endmodule

bind clock_pulse_generator_ctrl clock_ctrl_props u_props (.mclk(mclk), .reset(reset),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .standby_request(standby_request), .hw_standby_n(hw_standby_n), .clock_out(clock_out),
  .clock_out_oe(clock_out_oe), .clock_tick(clock_tick), .generator_running(generator_running),
  .active_multiplier(active_multiplier), .power_state(power_state));

/* testbench.sv */
// self-checking bench for the clock control block
`include "clk_pulse_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import clk_pulse_pkg::*;
  logic mclk = 0, reset = 1;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, active_multiplier;
  logic standby_request = 0, standby_wake = 0, hw_standby_n = 1;
  logic clock_out, clock_out_oe, clock_tick, generator_running, prev;
  cpg_state_t power_state;
  int err_total = 0, n_checks = 0, tk, tg;
  logic [31:0] seed = 32'h308a2ce0, rv;
  // expected answers, oldest first
  logic [31:0] exp_d[$];
  logic [1:0] exp_b[$], exp_r[$];
  always #12.5 mclk = ~mclk;
  clock_pulse_generator_ctrl u_dut (.mclk(mclk), .reset(reset), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .standby_request(standby_request), .standby_wake(standby_wake),
    .hw_standby_n(hw_standby_n), .clock_out(clock_out), .clock_out_oe(clock_out_oe),
    .clock_tick(clock_tick), .generator_running(generator_running),
    .active_multiplier(active_multiplier), .power_state(power_state));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one comparison, reported at once
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // a wait that ran out ends the run
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      $display("BAD %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  // write: offer both channels, release each when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] e);
    int n;
    logic ad, wd;
    exp_b.push_back(e);
    ad = 0;
    wd = 0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd) && n < 100) begin
      @(posedge mclk);
      n++;
      if (awready && !ad) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (wready && !wd) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    while (!bvalid && n < 100) begin
      @(posedge mclk);
      n++;
    end
    bready <= 1'b0;
    tmo(n, 100);
    @(posedge mclk);
  endtask
  // read: hold the address until taken, rready until data come
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    exp_d.push_back(d);
    exp_r.push_back(e);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // let an edge pass first so arvalid is seen high before it is released
    do begin
      @(posedge mclk);
      n++;
    end while (!arready && n < 100);
    arvalid <= 1'b0;
    while (!rvalid && n < 100) begin
      @(posedge mclk);
      n++;
    end
    rready <= 1'b0;
    tmo(n, 100);
    @(posedge mclk);
  endtask
  // bounded wait for the generator to run again; settle can reach 1024 cycles
  task automatic wait_run;
    int n;
    n = 0;
    while (!generator_running && n < 1200) begin
      @(posedge mclk);
      n++;
    end
    tmo(n, 1200);
  endtask
  // watcher: each bus answer against the oldest note
  always @(posedge mclk) begin
    if (bvalid && bready && exp_b.size() > 0) begin
      chk_v({30'h0, bresp}, {30'h0, exp_b.pop_front()}, "bresp");
    end
    if (rvalid && rready && exp_d.size() > 0) begin
      chk_v(rdata, exp_d.pop_front(), "rdata");
      chk_v({30'h0, rresp}, {30'h0, exp_r.pop_front()}, "rresp");
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    chk_v({30'h0, active_multiplier}, 0, "mult after reset");
    chk_v({31'h0, clock_out_oe}, 1, "pin enable");
    rd(`OFS_SYSTEM_CLOCK_CONTROL, 0, `RESP_OKAY);
    rd(`OFS_PLL_MULTIPLIER_CONTROL, 0, `RESP_OKAY);
    // spare bits are always written zero; fixed bits are written one to prove they ignore it
    wr(`OFS_SYSTEM_CLOCK_CONTROL, 32'hba, 4'h1, `RESP_OKAY);
    rd(`OFS_SYSTEM_CLOCK_CONTROL, 32'h8a, `RESP_OKAY);
    wr(`OFS_PLL_MULTIPLIER_CONTROL, 32'hf6, 4'h1, `RESP_OKAY);
    rd(`OFS_PLL_MULTIPLIER_CONTROL, 32'h02, `RESP_OKAY);
    chk_v({30'h0, active_multiplier}, 2, "immediate mult");
    rd(`OFS_CLOCK_STATUS, 32'h02, `RESP_OKAY);
    wr(`OFS_PLL_MULTIPLIER_CONTROL, 0, 4'h0, `RESP_OKAY);
    rd(`OFS_PLL_MULTIPLIER_CONTROL, 32'h02, `RESP_OKAY);
    wr(32'h10, 32'h01, 4'h1, `RESP_SLVERR);
    wr(`OFS_CLOCK_STATUS, 32'h01, 4'h1, `RESP_SLVERR);
    rd(32'h20, 0, `RESP_SLVERR);
    rv = $random(seed);
    wr(`OFS_STANDBY_CONTROL, rv, 4'h1, `RESP_OKAY);
    rd(`OFS_STANDBY_CONTROL, {28'h0, rv[3:0]}, `RESP_OKAY);
    // deferred switch: new value waits for software standby
    wr(`OFS_SYSTEM_CLOCK_CONTROL, 0, 4'h1, `RESP_OKAY);
    wr(`OFS_PLL_MULTIPLIER_CONTROL, 32'h01, 4'h1, `RESP_OKAY);
    chk_v({30'h0, active_multiplier}, 2, "mult held");
    standby_request <= 1'b1;
    @(posedge mclk);
    standby_request <= 1'b0;
    repeat (2) @(posedge mclk);
    chk_v({30'h0, power_state}, {30'h0, st_standby}, "standby");
    chk_v({30'h0, active_multiplier}, 1, "mult adopted");
    chk_v({31'h0, clock_out}, 1, "pin high");
    standby_wake <= 1'b1;
    wait_run();
    standby_wake <= 1'b0;
    chk_v({30'h0, power_state}, {30'h0, st_run}, "resumed");
    // divider codes 0 to 2, pin enabled and disabled
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 3; c++) begin
        wr(`OFS_SYSTEM_CLOCK_CONTROL, {24'h0, p[0], 4'h0, c[2:0]}, 4'h1, `RESP_OKAY);
        repeat (4) @(posedge mclk);
        tk = 0;
        tg = 0;
        prev = clock_out;
        repeat (32) begin
          @(posedge mclk);
          tk += (clock_tick === 1'b1);
          tg += (clock_out !== prev);
          prev = clock_out;
        end
        chk_v(tk, 32 >> c, "ticks");
        chk_v(tg, p ? 0 : 32 >> c, "pin toggles");
      end
    end
    hw_standby_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk_v({31'h0, clock_out_oe}, 0, "pin released");
    chk_v({30'h0, power_state}, {30'h0, st_hw_standby}, "hw standby");
    hw_standby_n <= 1'b1;
    wait_run();
    wrap_up();
  end
endmodule
